/* File: admc_regs.sv */
// Audio DAC mode-control register bank behind a classic Wishbone slave.
// Assumes a synchronous Wishbone master on core_clk and zero-detect
// inputs from the converter core on the same clock.
//
// Behaviour
// - Mute set ramps attenuator down to silence
// - Mute cleared ramps back to programmed level
// - Mute zero means normal operation; resets zero
// - Two mute bits, each for own channel
// - Rate bit selects 32x or 64x oversampling
// - Soft reset restores all defaults
// - Disable bit holds channel at bipolar zero
// - De-emphasis applied only when enabled
// - Two-bit field picks de-emphasis sample rate
// - Three-bit field picks serial data format
// - Rolloff bit picks sharp or slow filter
// - Phase bit inverts analog output
// - Polarity bit sets zero flag active level
// - Combine bit merges zero flags onto one pin
// - Word: bit15 zero, index 14:8, data 7:0
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module admc_regs
   import admc_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic leftZeroDetect,
   input wire logic rightZeroDetect,
   output logic [7:0] leftAtt,
   output logic [7:0] rightAtt,
   output logic leftChannelDisable,
   output logic rightChannelDisable,
   output logic overRate64,
   output logic deemphEnable,
   output logic [1:0] deemphRateSel,
   output logic [2:0] serialFormatSel,
   output logic formatReserved,
   output logic rolloffSel,
   output logic phaseInvert,
   output logic rightZeroFlag,
   output logic leftZeroFlag
);
   // Register storage
   logic [7:0] attLeftReg;
   logic [7:0] attRightReg;
   logic [7:0] muteRateReg;
   logic [7:0] chanDeemphReg;
   logic [7:0] formatReg;
   logic [7:0] phaseZeroReg;
   logic softRst;
   logic [31:0] stepCnt;
   logic stepTick;
   logic [7:0] leftAttNow;
   logic [7:0] rightAttNow;

   // Bus decode: word address, 16-bit control word in low lanes
   wire logic busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic [6:0] wordIdx = wb_adr_i[8:2];
   wire logic lowLanes = wb_sel_i[0] && wb_sel_i[1];
   // word check: bit 15 zero, embedded index matches
   wire logic wordOk = !wb_dat_i[WORD_TOP]
      && (wb_dat_i[14:IDX_LSB] == wordIdx) && lowLanes;
   wire logic doWrite = busReq && wb_we_i && wordOk;
   wire logic [7:0] wData = wb_dat_i[7:0];
   wire logic wrAttL = doWrite && (wordIdx == IDX_ATT_LEFT);
   wire logic wrAttR = doWrite && (wordIdx == IDX_ATT_RIGHT);
   wire logic wrMute = doWrite && (wordIdx == IDX_MUTE_RATE);
   wire logic wrChan = doWrite && (wordIdx == IDX_CHAN_DEEMPH);
   wire logic wrFmt = doWrite && (wordIdx == IDX_FORMAT);
   wire logic wrPhase = doWrite && (wordIdx == IDX_PHASE_ZERO);

   // Read-back data, index echoed in bits 14:8; unmapped reads zero
   logic [7:0] rdField;
   always_comb
   begin
      case (wordIdx)
         IDX_ATT_LEFT: rdField = attLeftReg;
         IDX_ATT_RIGHT: rdField = attRightReg;
         IDX_MUTE_RATE: rdField = muteRateReg;
         IDX_CHAN_DEEMPH: rdField = chanDeemphReg;
         IDX_FORMAT: rdField = formatReg;
         IDX_PHASE_ZERO: rdField = phaseZeroReg;
         IDX_STATUS: rdField = {6'h00,
            rightAttNow == ATT_SILENT, leftAttNow == ATT_SILENT};
         default: rdField = 8'h00;
      endcase
   end
   wire logic mapped = (wordIdx == IDX_ATT_LEFT)
      || (wordIdx == IDX_ATT_RIGHT) || (wordIdx == IDX_MUTE_RATE)
      || (wordIdx == IDX_CHAN_DEEMPH) || (wordIdx == IDX_FORMAT)
      || (wordIdx == IDX_PHASE_ZERO) || (wordIdx == IDX_STATUS);
   wire logic [31:0] rdWord = mapped ? {17'h00000, wordIdx, rdField}
      : 32'h00000000;

   // Bus answer: ack one cycle after request, dropped next cycle
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= busReq;
         wb_dat_o <= busReq ? rdWord : 32'h00000000;
      end
   end

   // soft reset pulse taken from written bit
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         softRst <= 1'b0;
      else
         softRst <= wrMute && wData[POS_SOFT_RESET];
   end

   // Attenuation registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         attLeftReg <= RST_ATT;
         attRightReg <= RST_ATT;
      end
      else if (softRst)
      begin
         attLeftReg <= RST_ATT;
         attRightReg <= RST_ATT;
      end
      else
      begin
         if (wrAttL)
            attLeftReg <= wData;
         if (wrAttR)
            attRightReg <= wData;
      end
   end

   // mode registers, reset defaults, reserved bits dropped
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         muteRateReg <= RST_MUTE_RATE;
         chanDeemphReg <= RST_CHAN_DEEMPH;
         formatReg <= RST_FORMAT;
         phaseZeroReg <= RST_PHASE_ZERO;
      end
      else if (softRst)
      begin
         muteRateReg <= RST_MUTE_RATE;
         chanDeemphReg <= RST_CHAN_DEEMPH;
         formatReg <= RST_FORMAT;
         phaseZeroReg <= RST_PHASE_ZERO;
      end
      else
      begin
         // Soft reset bit is self-clearing, never stored
         if (wrMute)
            muteRateReg <= wData & MASK_MUTE_RATE & 8'h7F;
         if (wrChan)
            chanDeemphReg <= wData & MASK_CHAN_DEEMPH;
         if (wrFmt)
            formatReg <= wData & MASK_FORMAT;
         if (wrPhase)
            phaseZeroReg <= wData & MASK_PHASE_ZERO;
      end
   end

   // Shared 8/fS step strobe
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         stepCnt <= 32'h00000000;
         stepTick <= 1'b0;
      end
      else if (stepCnt == 32'(STEP_CYC - 1))
      begin
         stepCnt <= 32'h00000000;
         stepTick <= 1'b1;
      end
      else
      begin
         stepCnt <= stepCnt + 32'h00000001;
         stepTick <= 1'b0;
      end
   end

   admc_ramp leftRamp (
      .core_clk(core_clk),
      .rst(rst),
      .softRst(softRst),
      .stepTick(stepTick),
      .silenceRampEn(muteRateReg[POS_LEFT_MUTE]),
      .attenuationLevel(attLeftReg),
      .attNow(leftAttNow)
   );
   admc_ramp rightRamp (
      .core_clk(core_clk),
      .rst(rst),
      .softRst(softRst),
      .stepTick(stepTick),
      .silenceRampEn(muteRateReg[POS_RIGHT_MUTE]),
      .attenuationLevel(attRightReg),
      .attNow(rightAttNow)
   );

   // zero flag routing, combined flag needs both channels zero
   wire logic combine = phaseZeroReg[POS_ZCOMB];
   wire logic rawPin11 = combine ? (leftZeroDetect && rightZeroDetect)
      : rightZeroDetect;
   wire logic rawPin12 = combine ? 1'b0 : leftZeroDetect;
   // polarity; unassigned pin idles at inactive level
   wire logic pol = phaseZeroReg[POS_ZPOL];
   wire logic [2:0] fmtSel = formatReg[2:0];
   wire logic fmtReserved = (fmtSel == FMT_RSV6) || (fmtSel == FMT_RSV7);

   // Registered attenuator codes to the converter core
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         leftAtt <= RST_ATT;
         rightAtt <= RST_ATT;
      end
      else
      begin
         leftAtt <= leftAttNow;
         rightAtt <= rightAttNow;
      end
   end

   // Registered channel, rate and de-emphasis controls
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         leftChannelDisable <= 1'b0;
         rightChannelDisable <= 1'b0;
         overRate64 <= 1'b0;
         deemphEnable <= 1'b0;
         deemphRateSel <= 2'h0;
      end
      else
      begin
         leftChannelDisable <= chanDeemphReg[POS_LEFT_DIS];
         rightChannelDisable <= chanDeemphReg[POS_RIGHT_DIS];
         overRate64 <= muteRateReg[POS_OVER];
         deemphEnable <= chanDeemphReg[POS_DEEMPH_EN];
         deemphRateSel <= chanDeemphReg[POS_DEEMPH_RATE +: 2];
      end
   end

   // Registered format, filter and phase controls
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         serialFormatSel <= RST_FORMAT[2:0];
         formatReserved <= 1'b0;
         rolloffSel <= 1'b0;
         phaseInvert <= 1'b0;
      end
      else
      begin
         serialFormatSel <= fmtSel;
         formatReserved <= fmtReserved;
         rolloffSel <= formatReg[POS_ROLLOFF];
         phaseInvert <= phaseZeroReg[POS_PHASE];
      end
   end

   // Registered zero flags on the two flag pins
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rightZeroFlag <= 1'b0;
         leftZeroFlag <= 1'b0;
      end
      else
      begin
         rightZeroFlag <= rawPin11 ^ pol;
         leftZeroFlag <= rawPin12 ^ pol;
      end
   end
endmodule : admc_regs

/* File: admc_pkg.sv */
// Package for the audio DAC mode-control register bank.
// Assumes a 32-bit classic Wishbone slave, one word per register.
package admc_pkg;
   // Register indices and byte offsets (offset = 4 * index)
   localparam logic [6:0] IDX_ATT_LEFT = 7'h10;
   localparam logic [6:0] IDX_ATT_RIGHT = 7'h11;
   localparam logic [6:0] IDX_MUTE_RATE = 7'h12;
   localparam logic [6:0] IDX_CHAN_DEEMPH = 7'h13;
   localparam logic [6:0] IDX_FORMAT = 7'h14;
   localparam logic [6:0] IDX_PHASE_ZERO = 7'h16;
   localparam logic [6:0] IDX_STATUS = 7'h17;
   // Control word fields
   localparam int WORD_TOP = 15;
   localparam int IDX_LSB = 8;
   // Register 18 field positions
   localparam int POS_LEFT_MUTE = 0;
   localparam int POS_RIGHT_MUTE = 1;
   localparam int POS_OVER = 6;
   localparam int POS_SOFT_RESET = 7;
   // Register 19 field positions
   localparam int POS_LEFT_DIS = 0;
   localparam int POS_RIGHT_DIS = 1;
   localparam int POS_DEEMPH_EN = 4;
   localparam int POS_DEEMPH_RATE = 5;
   // Register 20 field positions
   localparam int POS_FORMAT = 0;
   localparam int POS_ROLLOFF = 5;
   // Register 22 field positions
   localparam int POS_PHASE = 0;
   localparam int POS_ZPOL = 1;
   localparam int POS_ZCOMB = 2;
   // Writable-bit masks (reserved bits read back zero)
   localparam logic [7:0] MASK_MUTE_RATE = 8'hC3;
   localparam logic [7:0] MASK_CHAN_DEEMPH = 8'h73;
   localparam logic [7:0] MASK_FORMAT = 8'h27;
   localparam logic [7:0] MASK_PHASE_ZERO = 8'h07;
   // Reset values
   localparam logic [7:0] RST_ATT = 8'hFF;
   localparam logic [7:0] RST_MUTE_RATE = 8'h00;
   localparam logic [7:0] RST_CHAN_DEEMPH = 8'h00;
   localparam logic [7:0] RST_FORMAT = 8'h05;
   localparam logic [7:0] RST_PHASE_ZERO = 8'h00;
   // Attenuator codes: at or below this level the output is silent
   localparam logic [7:0] ATT_SILENT = 8'h80;
   // Default sample rate and core clock rate
   localparam int CLK_HZ = 250000000;
   localparam int FS_HZ = 48000;
   // Ramp step: one 0.5 dB step every 8 sample periods
   localparam int STEP_SAMPLES = 8;
   localparam int STEP_CYCLES = (CLK_HZ / FS_HZ) * STEP_SAMPLES;
   // Format codes
   typedef enum logic [2:0] {
      FMT_RJ24 = 3'h0, FMT_RJ20 = 3'h1, FMT_RJ18 = 3'h2, FMT_RJ16 = 3'h3,
      FMT_I2S = 3'h4, FMT_LJ = 3'h5, FMT_RSV6 = 3'h6, FMT_RSV7 = 3'h7
   } admc_format_e;
endpackage : admc_pkg

/* File: admc_ramp.sv */
// One channel's soft-mute attenuator ramp.
// Assumes a shared step strobe from the parent, one cycle per 8/fS.
`timescale 1ns/1ns
module admc_ramp
   import admc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic softRst,
   input wire logic stepTick,
   input wire logic silenceRampEn,
   input wire logic [7:0] attenuationLevel,
   output logic [7:0] attNow
);
   // Target is silence while muted, else the programmed level; codes
   // below silence are mute too, so the ramp never runs past silence
   wire logic levelMute = attenuationLevel < ATT_SILENT;
   wire logic [7:0] target = (silenceRampEn || levelMute) ? ATT_SILENT
      : attenuationLevel;
   wire logic below = attNow < target;
   wire logic above = attNow > target;
   logic [7:0] next_attNow;

   // one step toward target from current level
   always_comb
   begin
      next_attNow = attNow;
      if (stepTick && below)
         next_attNow = attNow + 8'h01;
      else if (stepTick && above)
         next_attNow = attNow - 8'h01;
   end

   // Ramp state register
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         attNow <= RST_ATT;
      else if (softRst)
         attNow <= RST_ATT;
      else
         attNow <= next_attNow;
   end
endmodule : admc_ramp

/* File: admc_regs_properties.sv */
// Port checks for the mode-control bank: bus answer and ramp shape.
// Assumes binding onto admc_regs; ramps never see a soft reset off FF.
`timescale 1ns/1ns
module admc_regs_properties
   import admc_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] leftAtt,
   input wire logic [7:0] rightAtt,
   input wire logic [2:0] serialFormatSel,
   input wire logic formatReserved
);
   int sinceL;
   logic [7:0] prevL;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Cycles since the left attenuator last moved, saturating at a step
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sinceL <= 0;
         prevL <= RST_ATT;
      end
      else
      begin
         prevL <= leftAtt;
         if (leftAtt != prevL)
            sinceL <= 0;
         else if (sinceL < STEP_CYC)
            sinceL <= sinceL + 1;
      end
   end
   a_ack_next: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
      else $error("ack without request");
   a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside answer");
   a_att_step: assert property (
      $changed(leftAtt) || $changed(rightAtt)
      |-> leftAtt - $past(leftAtt) inside {0, 1, -1}
      && rightAtt - $past(rightAtt) inside {0, 1, -1})
      else $error("attenuator jumped");
   a_step_spacing: assert property (
      $changed(leftAtt) |-> sinceL >= STEP_CYC - 1)
      else $error("attenuator steps too close");
   a_mute_floor: assert property (leftAtt >= ATT_SILENT
      && rightAtt >= ATT_SILENT)
      else $error("ramp below silence");
   a_fmt_reserved: assert property (
      formatReserved == (serialFormatSel[2:1] == 2'b11))
      else $error("reserved format flag wrong");
   c_silent: cover property (leftAtt == ATT_SILENT);
   c_fmt_rsv: cover property (formatReserved);
   c_read: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule : admc_regs_properties

bind admc_regs admc_regs_properties #(.STEP_CYC(STEP_CYC)) chk_u (
   .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .leftAtt(leftAtt), .rightAtt(rightAtt),
   .serialFormatSel(serialFormatSel), .formatReserved(formatReserved));

/* File: admc_host.sv */
// Host model: classic Wishbone master issuing 16-bit control words.
// Assumes the bench bounds any wait for the answer.
`timescale 1ns/1ns
module admc_host
   import admc_pkg::*;
(
   input wire logic core_clk,
   input wire logic ack,
   input wire logic [31:0] datR,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [8:0] adr,
   output logic [3:0] sel,
   output logic [31:0] datW
);
   // Bus idle from time zero
   initial
   begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 9'h000;
      sel = 4'h0;
      datW = 32'h0;
   end
   task automatic xfer(input logic w, input logic [6:0] i,
      input logic [7:0] f, input logic top, output logic [31:0] q);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      sel <= 4'hF;
      datW <= {16'h0000, top, i, f};
      do @(posedge core_clk); while (ack !== 1'b1);
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask : xfer
endmodule : admc_host

/* File: audio_dac_mode_control_test.sv */
// Self-checking bench: host model drives words, a field model predicts.
// Assumes a short ramp step of 4 cycles in the bank.
`timescale 1ns/1ns
module audio_dac_mode_control_test;
   import admc_pkg::*;
   localparam int SC = 4;
   logic core_clk, rst, cyc, stb, we, ack, lz, rz;
   logic [8:0] adr;
   logic [3:0] sel;
   logic [31:0] datW, datR, q, r;
   logic [7:0] lAtt, rAtt;
   logic lDis, rDis, ov, dEn, fRsv, roll, ph, zR, zL;
   logic [1:0] dRate;
   logic [2:0] fmt;
   logic [7:0] mdl [0:127];
   int err_total = 0;
   int n_checks = 0;
   int n;
   admc_host host_u (.core_clk(core_clk), .ack(ack), .datR(datR),
      .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .datW(datW));
   admc_regs #(.STEP_CYC(SC)) dut_u (.core_clk(core_clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
      .leftZeroDetect(lz), .rightZeroDetect(rz), .leftAtt(lAtt),
      .rightAtt(rAtt), .leftChannelDisable(lDis),
      .rightChannelDisable(rDis), .overRate64(ov), .deemphEnable(dEn),
      .deemphRateSel(dRate), .serialFormatSel(fmt),
      .formatReserved(fRsv), .rolloffSel(roll), .phaseInvert(ph),
      .rightZeroFlag(zR), .leftZeroFlag(zL));
   // Clock
   always #2 core_clk = ~core_clk;
   task results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Bits kept by each index; soft reset never reads back
   function automatic logic [7:0] msk(input logic [6:0] i);
      case (i)
         IDX_ATT_LEFT, IDX_ATT_RIGHT: return 8'hFF;
         IDX_MUTE_RATE: return MASK_MUTE_RATE & 8'h7F;
         IDX_CHAN_DEEMPH: return MASK_CHAN_DEEMPH;
         IDX_FORMAT: return MASK_FORMAT;
         IDX_PHASE_ZERO: return MASK_PHASE_ZERO;
         default: return 8'h00;
      endcase
   endfunction : msk
   task mreset;
      foreach (mdl[j]) mdl[j] = 8'h00;
      mdl[IDX_ATT_LEFT] = RST_ATT;
      mdl[IDX_ATT_RIGHT] = RST_ATT;
      mdl[IDX_FORMAT] = RST_FORMAT;
   endtask : mreset
   task wr(input logic [6:0] i, input logic [7:0] f, input logic top);
      host_u.xfer(1'b1, i, f, top, q);
      if (!top)
         mdl[i] = f & msk(i);
      if (!top && i == IDX_MUTE_RATE && f[7])
         mreset();
   endtask : wr
   // Mode outputs, zero flags and readbacks of indices 16 to 22 against the model
   task outs;
      logic [7:0] a, b, d, e;
      logic [1:0] z;
      repeat (2) @(posedge core_clk);
      a = mdl[IDX_MUTE_RATE];
      b = mdl[IDX_CHAN_DEEMPH];
      d = mdl[IDX_FORMAT];
      e = mdl[IDX_PHASE_ZERO];
      z = e[2] ? {(lz & rz) ^ e[1], e[1]} : {rz ^ e[1], lz ^ e[1]};
      chk("overRate", ov, a[6]);
      chk("disable", {lDis, rDis}, {b[0], b[1]});
      chk("deemph", {dEn, dRate}, {b[4], b[6:5]});
      chk("format", {fmt, fRsv}, {d[2:0], d[2:1] == 2'b11});
      chk("filterPhase", {roll, ph}, {d[5], e[0]});
      chk("zeroFlags", {zR, zL}, z);
      foreach (mdl[i])
         if (i >= 16 && i <= 22)
         begin
            host_u.xfer(1'b0, 7'(i), 8'h00, 1'b0, q);
            chk("readback", q, msk(i) ? {17'h0, 7'(i), mdl[i]} : 0);
         end
   endtask : outs
   // Watchdog
   initial
   begin
      #80000;
      err_total++;
      results();
   end
   initial
   begin
      core_clk = 1'b0;
      rst = 1'b1;
      lz = 1'b0;
      rz = 1'b0;
      void'($urandom(76));
      mreset();
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      outs();
      chk("attReset", {lAtt, rAtt}, 16'hFFFF);
      for (int k = 0; k < 16; k++)
      begin
         r = $urandom;
         lz <= r[8];
         rz <= r[9];
         wr(IDX_FORMAT, r[7:0] & 8'h20 | 8'(k % 8), 1'b0);
         wr(IDX_CHAN_DEEMPH, r[15:8] & 8'h13 | 8'(k % 3) << 5, 1'b0);
         wr(IDX_PHASE_ZERO, 8'(k % 8), 1'b0);
         wr(IDX_MUTE_RATE, r[23:16] & 8'h40, 1'b0);
         outs();
      end
      wr(IDX_FORMAT, 8'h03, 1'b1);
      wr(7'h15, 8'h55, 1'b0);
      outs();
      wr(IDX_MUTE_RATE, 8'h01, 1'b0);
      for (n = 0; n < 2000 && lAtt !== ATT_SILENT; n++) @(posedge core_clk);
      chk("rampTime", n >= 126 * SC && n <= 128 * SC, 1);
      chk("rightIdle", rAtt, 8'hFF);
      host_u.xfer(1'b0, IDX_STATUS, 8'h00, 1'b0, q);
      chk("status", q, {17'h0, IDX_STATUS, 8'h01});
      wr(IDX_MUTE_RATE, 8'h02, 1'b0);
      repeat (100) @(posedge core_clk);
      chk("leftUp", lAtt inside {[8'h97 : 8'h9B]}, 1);
      chk("rightDown", rAtt inside {[8'hE4 : 8'hE8]}, 1);
      host_u.xfer(1'b0, IDX_STATUS, 8'h00, 1'b0, q);
      chk("statusMid", q, {17'h0, IDX_STATUS, 8'h00});
      wr(IDX_MUTE_RATE, 8'h00, 1'b0);
      for (n = 0; n < 2000 && {lAtt, rAtt} !== 16'hFFFF; n++)
         @(posedge core_clk);
      chk("attBack", {lAtt, rAtt}, 16'hFFFF);
      wr(IDX_FORMAT, 8'h24, 1'b0);
      wr(IDX_MUTE_RATE, 8'hC0, 1'b0);
      outs();
      results();
   end
endmodule : audio_dac_mode_control_test
